// ### timing_pkg.sv
// Constants for the instruction length and timing decoder.
// Assumes an 8-bit core with one system clock; every count is in clock cycles.
// Overview of operation
// - OR/XOR into accumulator: 1/1, 2/2, indirect 1/2
// - OR/XOR immediate into direct 3/3; from accumulator 2/2
// - Accumulator clear, complement, rotate, swap: 1/1
// - Internal moves take cycles equal bytes; indirect one-byte 2
// - Direct-to-direct and immediate-to-direct moves 3/3
// - Data pointer constant load 3 bytes, 3 cycles
// - Code byte read: 1 byte, 3 cycles
// - External data moves: 1 byte, 3 cycles
// - Stack push and pop: 2 bytes, 2 cycles
// - Exchanges 1/1, direct 2/2, indirect 1/2
// - Carry-only booleans 1/1; direct-bit booleans 2/2
// - Carry and zero jumps: 2 not taken, 4 taken
// - Bit, compare, direct-decrement jumps: 3 or 5
// - Compare indirect immediate jump: 4 or 6
// - Short call 2 bytes 4; long call 3 bytes 5
// - Short, relative, indirect jumps 4; long 5; returns 6
// - Register decrement jump: 2 bytes, 2 or 4
// - Relative target: next address plus signed offset
// - Direct address low half RAM, high half special
// - Short target stays inside next instruction's 2 kB page
// - Undefined opcode acts as one-cycle no-operation
// - Register operands pick bank register; indirect uses R0/R1
// - Bank select maps banks to 0x00,0x08,0x10,0x18
// - Not-taken branch finishes earlier; counts in clocks
package timing_pkg;
  localparam int          CLK_PERIOD_NS   = 8;
  localparam logic [7:0]  UNDEF_OPCODE    = 8'hA5;
  localparam logic [7:0]  SFR_BASE        = 8'h80;
  localparam int          BANK_SIZE_LOG2  = 3;
  localparam int          BANK_FIELD_W    = 2;
  localparam int          PAGE_BITS       = 11;
  localparam logic [15:0] PC_RESET        = 16'h0000;
  localparam logic [3:0]  CYC_MAX         = 4'h8;

  // Operand address classes; the decoder does not report them on any port
  typedef enum logic [1:0] {
    opd_none_type_e,
    opd_bank_reg,
    opd_indirect,
    opd_direct
  } operand_type;
endpackage : timing_pkg

// ### opcode_timing_rom.sv
// Registered lookup of byte length and clock counts for each opcode.
// Assumes the opcode is presented one cycle before its timing is needed.
`timescale 1ns/10ps
module opcode_timing_rom (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // Lookup
  input  wire logic [7:0] opcode,
  output logic      [1:0] byte_len,
  output logic      [3:0] cyc_base,
  output logic      [3:0] cyc_taken,
  output logic            is_cond
);
  logic [1:0] len_nxt;
  logic [3:0] base_nxt;
  logic [3:0] taken_nxt;
  logic       cond_nxt;

  // Decode timing from opcode groups
  always_comb begin
    len_nxt   = 2'd1;
    base_nxt  = 4'h1;
    taken_nxt = 4'h1;
    cond_nxt  = 1'b0;
    casez (opcode)
      8'h?1: begin                                    // Short jump / call
        len_nxt  = 2'd2;
        base_nxt = 4'h4;
      end
      8'h02, 8'h12: begin                             // Long jump / call
        len_nxt  = 2'd3;
        base_nxt = 4'h5;
      end
      8'h22, 8'h32: base_nxt = 4'h6;
      8'h80, 8'h73: begin
        len_nxt  = (opcode == 8'h80) ? 2'd2 : 2'd1;
        base_nxt = 4'h4;
      end
      8'h40, 8'h50, 8'h60, 8'h70: begin
        len_nxt = 2'd2; base_nxt = 4'h2; taken_nxt = 4'h4; cond_nxt = 1'b1;
      end
      8'hD8, 8'hD9, 8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hDF: begin
        len_nxt = 2'd2; base_nxt = 4'h2; taken_nxt = 4'h4; cond_nxt = 1'b1;
      end
      8'h10, 8'h20, 8'h30, 8'hB4, 8'hB5, 8'hD5,
      8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF: begin
        len_nxt = 2'd3; base_nxt = 4'h3; taken_nxt = 4'h5; cond_nxt = 1'b1;
      end
      8'hB6, 8'hB7: begin
        len_nxt = 2'd3; base_nxt = 4'h4; taken_nxt = 4'h6; cond_nxt = 1'b1;
      end
      8'h43, 8'h53, 8'h63, 8'h75, 8'h85, 8'h90: begin
        len_nxt = 2'd3; base_nxt = 4'h3;
      end
      8'h83, 8'h93, 8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: begin
        base_nxt = 4'h3;
      end
      8'hA4: base_nxt = 4'h4;
      8'h84: base_nxt = 4'h8;
      8'hC3, 8'hD3, 8'hB3, 8'hA5, 8'h00: base_nxt = 4'h1;
      8'h72, 8'hA0, 8'hA2, 8'hB0, 8'h82, 8'h92, 8'hB2, 8'hC2, 8'hD2,
      8'hC0, 8'hD0, 8'h42, 8'h52, 8'h62, 8'h44, 8'h54, 8'h64, 8'h74,
      8'h24, 8'h34, 8'h94, 8'h05, 8'h15, 8'h45, 8'h55, 8'h65, 8'hE5,
      8'hF5, 8'h25, 8'h35, 8'h95, 8'hC5, 8'hA6, 8'hA7, 8'h86, 8'h87,
      8'h76, 8'h77: begin
        len_nxt = 2'd2; base_nxt = 4'h2;
      end
      8'h?6, 8'h?7: begin
        base_nxt = 4'h2;
      end
      8'b1010_1???, 8'b0111_1???, 8'b1000_1???: begin
        len_nxt = 2'd2; base_nxt = 4'h2;
      end
      8'h?4: base_nxt = 4'h1;
      default: base_nxt = 4'h1;
    endcase
  end

  // Registered read data
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      byte_len  <= 2'd1;
      cyc_base  <= 4'h1;
      cyc_taken <= 4'h1;
      is_cond   <= 1'b0;
    end else begin
      byte_len  <= len_nxt;
      cyc_base  <= base_nxt;
      cyc_taken <= taken_nxt;
      is_cond   <= cond_nxt;
    end
  end
endmodule : opcode_timing_rom

// ### operand_address_gen.sv
// Forms operand and branch target addresses.
// Assumes fields are held stable while the instruction executes.
`timescale 1ns/10ps
module operand_address_gen (
  // Operand fields
  input  wire logic [7:0]  opcode,
  input  wire logic [1:0]  bank_select_field,
  input  wire logic [7:0]  direct_addr,
  input  wire logic [7:0]  pointer_value,
  // Branch fields
  input  wire logic [15:0] next_pc,
  input  wire logic [7:0]  rel_offset,
  input  wire logic [7:0]  target_low,
  input  wire logic [7:0]  target_high,
  // Results
  output logic      [7:0]  bank_reg_addr,
  output logic      [7:0]  indirect_addr,
  output logic             direct_is_sfr,
  output logic      [15:0] rel_target,
  output logic      [15:0] short_target,
  output logic      [15:0] long_target
);
  // Bank register address from bank and register number
  assign bank_reg_addr = {3'b000, bank_select_field, opcode[2:0]};
  assign indirect_addr = pointer_value;
  assign direct_is_sfr = (direct_addr >= timing_pkg::SFR_BASE);
  // Signed offset from next instruction
  assign rel_target = next_pc + {{8{rel_offset[7]}}, rel_offset};
  // Page bits kept from next instruction address
  assign short_target = {next_pc[15:timing_pkg::PAGE_BITS], opcode[7:5], target_low};
  assign long_target  = {target_high, target_low};
endmodule : operand_address_gen

// ### instruction_timing_decoder.sv
// Instruction sequencer: fetch, operand gather and cycle timing.
// Assumes program memory returns prog_data in the cycle it is addressed.
`timescale 1ns/10ps
module instruction_timing_decoder (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Program memory
  output logic      [15:0] prog_addr,
  input  wire logic [7:0]  prog_data,
  // Core state inputs
  input  wire logic [1:0]  bank_select_field,
  input  wire logic [7:0]  pointer_value,
  input  wire logic        branch_taken,
  // Decoded results
  output logic             issue,
  output logic      [7:0]  cur_opcode,
  output logic      [1:0]  cur_len,
  output logic      [3:0]  cur_cycles,
  output logic      [7:0]  bank_reg_addr,
  output logic      [7:0]  indirect_addr,
  output logic             direct_is_sfr,
  output logic      [15:0] jump_target
);
  typedef enum logic [1:0] {fetch_st, operand_st, wait_st} seq_type;
  seq_type     state_r, state_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [7:0]  op_r, op_nxt;
  logic [7:0]  b1_r, b1_nxt;
  logic [7:0]  b2_r, b2_nxt;
  logic [1:0]  idx_r, idx_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [3:0]  cyc_r, cyc_nxt;
  logic        iss_r, iss_nxt;
  logic [1:0]  len;
  logic [3:0]  cb, ct;
  logic        cond;
  logic [15:0] rel_t, sh_t, lg_t;
  logic [7:0]  rel_b;

  opcode_timing_rom u_rom (
    .mclk      (mclk),
    .reset     (reset),
    .opcode    (op_nxt),                               // Next opcode value (prog_data at fetch), not operand bytes
    .byte_len  (len),
    .cyc_base  (cb),
    .cyc_taken (ct),
    .is_cond   (cond)
  );

  assign rel_b = (len == 2'd3) ? b2_r : b1_r;
  operand_address_gen u_addr (
    .opcode            (op_r),
    .bank_select_field (bank_select_field),
    .direct_addr       (b1_r),
    .pointer_value     (pointer_value),
    .next_pc           (pc_r),
    .rel_offset        (rel_b),
    .target_low        ((len == 2'd3) ? b2_r : b1_r),
    .target_high       (b1_r),
    .bank_reg_addr     (bank_reg_addr),
    .indirect_addr     (indirect_addr),
    .direct_is_sfr     (direct_is_sfr),
    .rel_target        (rel_t),
    .short_target      (sh_t),
    .long_target       (lg_t)
  );

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    pc_nxt    = pc_r;
    op_nxt    = op_r;
    b1_nxt    = b1_r;
    b2_nxt    = b2_r;
    idx_nxt   = idx_r;
    cnt_nxt   = cnt_r;
    cyc_nxt   = cyc_r;
    iss_nxt   = 1'b0;
    case (state_r)
      fetch_st: begin
        op_nxt    = prog_data;
        pc_nxt    = pc_r + 16'h0001;
        idx_nxt   = 2'd1;
        cnt_nxt   = 4'h1;
        state_nxt = operand_st;
      end
      operand_st: begin
        // Gather remaining bytes, one per cycle
        if (idx_r < len) begin
          if (idx_r == 2'd1) b1_nxt = prog_data;
          else               b2_nxt = prog_data;
          pc_nxt  = pc_r + 16'h0001;
          idx_nxt = idx_r + 2'd1;
          cnt_nxt = cnt_r + 4'h1;
        end else begin
          // Not-taken uses base count, taken uses longer count
          cyc_nxt = (cond && branch_taken) ? ct : cb;
          iss_nxt = 1'b1;
          state_nxt = wait_st;
        end
      end
      wait_st: begin
        // Hold off next fetch until count elapses
        if (cnt_r >= cyc_r) begin
          state_nxt = fetch_st;
        end else begin
          cnt_nxt = cnt_r + 4'h1;
        end
      end
      default: state_nxt = fetch_st;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r <= fetch_st;
      pc_r    <= timing_pkg::PC_RESET;
      op_r    <= 8'h00;
      b1_r    <= 8'h00;
      b2_r    <= 8'h00;
      idx_r   <= 2'd0;
      cnt_r   <= 4'h0;
      cyc_r   <= 4'h1;
      iss_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
      op_r    <= op_nxt;
      b1_r    <= b1_nxt;
      b2_r    <= b2_nxt;
      idx_r   <= idx_nxt;
      cnt_r   <= cnt_nxt;
      cyc_r   <= cyc_nxt;
      iss_r   <= iss_nxt;
    end
  end

  // Outputs
  assign prog_addr  = pc_r;
  assign issue      = iss_r;
  assign cur_opcode = op_r;
  assign cur_len    = len;
  assign cur_cycles = cyc_r;
  assign jump_target = (op_r[3:0] == 4'h1) ? sh_t :
                       ((op_r == 8'h02) || (op_r == 8'h12)) ? lg_t : rel_t;
endmodule : instruction_timing_decoder

// ### prog_memory_model.sv
// Program memory partner: a byte array answering in the addressed cycle.
// Assumes the testbench loads the image before reset is released.
`timescale 1ns/10ps
module prog_memory_model (
  // Fetch port
  input  wire logic [15:0] prog_addr,
  output logic      [7:0]  prog_data
);
  logic [7:0] mem [0:1023];

  // Byte at the fetch address, same cycle
  assign prog_data = mem[prog_addr[9:0]];
endmodule : prog_memory_model

// ### decoder_timing_monitor.sv
// Checker for the instruction timing decoder, watching its ports only.
// Assumes one clock domain; bound into every decoder instance.
`timescale 1ns/10ps
module decoder_timing_monitor (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // Observed ports
  input wire logic [1:0] bank_select_field,
  input wire logic [7:0] pointer_value,
  input wire logic       branch_taken,
  input wire logic       issue,
  input wire logic [7:0] cur_opcode,
  input wire logic [1:0] cur_len,
  input wire logic [3:0] cur_cycles,
  input wire logic [7:0] bank_reg_addr,
  input wire logic [7:0] indirect_addr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic [4:0] gap_r, gap_nxt;
  logic [3:0] last_r, last_nxt;

  // Cycles since the last issue and the count that issue promised
  always_comb begin
    gap_nxt  = issue ? 5'h01 : ((gap_r == 5'h1F) ? gap_r : gap_r + 5'h01);
    last_nxt = issue ? cur_cycles : last_r;
  end

  // Gap registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      gap_r  <= 5'h1F;
      last_r <= 4'h0;
    end else begin
      gap_r  <= gap_nxt;
      last_r <= last_nxt;
    end
  end

  a_issue_spacing: assert property (issue |-> gap_r >= {1'b0, last_r})
    else $error("issue before previous count elapsed");
  a_cycles_hold: assert property (!issue |-> $stable(cur_cycles))
    else $error("cycle count changed between issues");
  a_undef_nop: assert property (issue && cur_opcode == timing_pkg::UNDEF_OPCODE
    |-> cur_len == 2'h1 && cur_cycles == 4'h1) else $error("undefined opcode timing wrong");
  a_acc_single: assert property (issue && cur_opcode inside {8'hE4, 8'hF4, 8'h23, 8'h33,
    8'h03, 8'h13, 8'hC4} |-> cur_len == 2'h1 && cur_cycles == 4'h1)
    else $error("accumulator op timing wrong");
  a_short_branch: assert property (issue && (cur_opcode inside {8'h40, 8'h50, 8'h60,
    8'h70} || cur_opcode[7:3] == 5'h1B) |-> cur_cycles == ($past(branch_taken) ? 4'h4 : 4'h2))
    else $error("two-byte branch timing wrong");
  a_cmp_indirect: assert property (issue && cur_opcode[7:1] == 7'h5B
    |-> cur_cycles == ($past(branch_taken) ? 4'h6 : 4'h4))
    else $error("indirect compare timing wrong");
  a_long_xfer: assert property (issue && cur_opcode inside {8'h02, 8'h12}
    |-> cur_len == 2'h3 && cur_cycles == 4'h5) else $error("long transfer timing wrong");
  a_bank_addr: assert property (issue && cur_opcode[3]
    |-> bank_reg_addr == {3'h0, bank_select_field, cur_opcode[2:0]})
    else $error("bank register address wrong");
  a_indirect_addr: assert property (issue && cur_opcode[3:1] == 3'h3
    |-> indirect_addr == pointer_value) else $error("indirect address wrong");

  // Outcome was sampled at the decision edge, one cycle before issue
  c_taken: cover property (issue && $past(branch_taken) && cur_cycles == 4'h4);
  c_undef: cover property (issue && cur_opcode == timing_pkg::UNDEF_OPCODE);
  c_cmp: cover property (issue && cur_opcode == 8'hB6 && $past(branch_taken));
endmodule : decoder_timing_monitor

bind instruction_timing_decoder decoder_timing_monitor u_mon (.*);

// ### byte_cpu_instruction_timing_decoder_tb.sv
// Testbench: runs an image of timed instructions through the decoder twice.
// Assumes branches point at the next instruction, so flow stays linear.
`timescale 1ns/10ps
module byte_cpu_instruction_timing_decoder_tb;
  typedef struct {
    logic [7:0]  op;
    logic [1:0]  len;
    logic [3:0]  cyc;
    logic [15:0] tgt;
    bit          ct;
    logic        special_function_register;
  } exp_type;
  // Entries: opcode, bytes, cycles not taken, cycles taken
  localparam logic [19:0] TAB [79] = '{
    20'h48111, 20'h45222, 20'h46122, 20'h44222, 20'h68111, 20'h65222, 20'h66122,
    20'h64222, 20'h43333, 20'h42222, 20'h63333, 20'h62222, 20'hE4111, 20'hF4111,
    20'h23111, 20'h33111, 20'h03111, 20'h13111, 20'hC4111, 20'hE8111, 20'hE5222,
    20'hE6122, 20'h74222, 20'hF8111, 20'hA8222, 20'h78222, 20'hF5222, 20'h88222,
    20'h86222, 20'hF6122, 20'hA6222, 20'h76222, 20'h85333, 20'h75333, 20'h90333,
    20'h93133, 20'h83133, 20'hE2133, 20'hF2133, 20'hE0133, 20'hF0133, 20'hC0222,
    20'hD0222, 20'hC8111, 20'hC5222, 20'hC6122, 20'hD6122, 20'hC3111, 20'hD3111,
    20'hB3111, 20'hC2222, 20'hD2222, 20'hB2222, 20'h82222, 20'hB0222, 20'h72222,
    20'hA0222, 20'hA2222, 20'h92222, 20'h40224, 20'h50224, 20'h60224, 20'h70224,
    20'hD8224, 20'h20335, 20'h30335, 20'h10335, 20'hB5335, 20'hB4335, 20'hB8335,
    20'hD5335, 20'hB6346, 20'h11244, 20'h12355, 20'h01244, 20'h80244, 20'h02355,
    20'hA5111, 20'h00111};
  logic        mclk, reset, issue, direct_is_sfr, branch_taken;
  logic [15:0] prog_addr, jump_target;
  logic [7:0]  prog_data, pointer_value, cur_opcode, bank_reg_addr, indirect_addr;
  logic [1:0]  bank_select_field, cur_len;
  logic [3:0]  cur_cycles;
  logic [15:0] pc;
  exp_type     exp_q[$];
  logic        bt_q[$];
  int          error_cnt, n_compared, bt_i, w;

  instruction_timing_decoder u_dut (.*);
  prog_memory_model u_mem (.*);

  // Clock at 125 MHz
  always #4 mclk = ~mclk;

  // Compare one value against its expectation
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
    n_compared++;
    if (seen !== expv) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, expv, seen);
    end
  endtask : check

  // Report counts and end the run
  task automatic end_sim();
    $display("Compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // Lay one pass of the table into memory and note what each issue must show
  task automatic load_pass();
    logic [19:0] e;
    logic [15:0] nx;
    exp_type     x;
    logic        bt;
    for (int i = 0; i < 79; i++) begin
      e  = TAB[i];
      bt = 1'($urandom);
      nx = pc + 16'(e[11:8]);
      x.op = e[19:12];
      for (int k = 1; k < 4; k++) u_mem.mem[pc[9:0] + 10'(k)] = 8'($urandom);
      if (e[7:4] != e[3:0] || x.op == 8'h80) u_mem.mem[nx[9:0] - 10'h1] = 8'h00;
      if (x.op inside {8'h01, 8'h11}) begin
        x.op = {nx[10:8], e[16:12]};
        u_mem.mem[pc[9:0] + 10'h1] = nx[7:0];
      end
      if (x.op inside {8'h02, 8'h12}) begin
        u_mem.mem[pc[9:0] + 10'h1] = nx[15:8];
        u_mem.mem[pc[9:0] + 10'h2] = nx[7:0];
      end
      u_mem.mem[pc[9:0]] = x.op;
      x.special_function_register = (u_mem.mem[pc[9:0] + 10'h1] >= timing_pkg::SFR_BASE);
      x.len = e[9:8];
      x.cyc = bt ? e[3:0] : e[7:4];
      x.tgt = nx;
      x.ct  = (e[7:4] != e[3:0]) || (e[19:12] inside {8'h80, 8'h01, 8'h11, 8'h02, 8'h12});
      exp_q.push_back(x);
      bt_q.push_back(bt);
      pc = nx;
    end
  endtask : load_pass

  // After each issue, present the next branch outcome and new core state
  always @(negedge mclk) begin
    if (!reset && issue === 1'b1 && bt_i + 1 < bt_q.size()) begin
      bt_i++;
      branch_taken      = bt_q[bt_i];
      bank_select_field = 2'($urandom);
      pointer_value     = 8'($urandom);
    end
  end

  // Take the oldest note at each issue and compare
  always @(negedge mclk) begin
    exp_type x;
    if (!reset && issue === 1'b1 && exp_q.size() > 0) begin
      x = exp_q.pop_front();
      check("opcode", 16'(cur_opcode), 16'(x.op));
      check("length", 16'(cur_len), 16'(x.len));
      check("cycles", 16'(cur_cycles), 16'(x.cyc));
      if (x.ct) check("target", jump_target, x.tgt);
      if (x.len > 2'd1) check("sfr", 16'(direct_is_sfr), 16'(x.special_function_register));
    end
  end

  // Watchdog
  initial begin
    #(8 * 20000);
    error_cnt++;
    end_sim();
  end

  // Main sequence
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    bank_select_field = 2'h0;
    pointer_value = 8'h00;
    branch_taken = 1'b0;
    void'($urandom(76));
    for (int i = 0; i < 1024; i++) u_mem.mem[i] = timing_pkg::UNDEF_OPCODE;
    pc = timing_pkg::PC_RESET;
    load_pass();
    load_pass();
    branch_taken = bt_q[0];
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    for (w = 0; w < 5000 && exp_q.size() > 0; w++) @(posedge mclk);
    check("pending", 16'(exp_q.size()), 16'h0000);
    end_sim();
  end
endmodule : byte_cpu_instruction_timing_decoder_tb
